// File: rtl/amp_regs.sv
// Register bank and input switching for the on-chip amplifier
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "amp_cfg.svh"

module amp_regs
    import amp_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Register port
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [31:0]   rdata,
    // Timer switch input
    input  wire logic          timer_compare_switch_signal,
    // Analog control
    output amp_drive_type      drive
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [31:0]   ctrl_q;
    logic [31:0]   ctrl_d;
    logic          lock_bit_q;
    logic          lock_bit_d;
    logic          lock_used_q;
    logic          lock_used_d;
    logic [31:0]   rdata_d;
    amp_drive_type drive_d;

    always_comb
    begin
        ctrl_d      = ctrl_q;
        lock_bit_d  = lock_bit_q;
        lock_used_d = lock_used_q;
        rdata_d     = 32'h0000_0000;
        // Only reserved bits are masked, so they always hold reset value
        if (wr && addr == `AMP_CTRL_OFFSET && !lock_bit_q)
        begin
            ctrl_d = wdata & `AMP_CTRL_WMASK | wdata & `AMP_CTRL_WMASK_EN;
        end
        // Locked writes fall through with no error
        // First write wins; no later path clears it
        if (wr && addr == `AMP_LOCK_OFFSET && !lock_used_q)
        begin
            lock_bit_d  = wdata[`AMP_LOCK_BIT];
            lock_used_d = 1'b1;
        end
        if (rd)
        begin
            case (addr)
                `AMP_CTRL_OFFSET: rdata_d = ctrl_q;
                `AMP_LOCK_OFFSET: rdata_d = {31'h0000_0000, lock_bit_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Gain decode, one flag per gain step
    // ----------------------------------------
    logic [2:0]    gain_code;
    logic [5:0]    gain_dec;

    assign gain_code = ctrl_q[`AMP_GAIN_LSB +: 3];

    // Undefined codes fall back to x2 so the feedback net is never left open
    for (genvar g = 0; g < 6; g++)
    begin : g_gain
        if (g == 0)
        begin : g_low
            assign gain_dec[g] = (gain_code == 3'h0) || (gain_code > `AMP_GAIN_MAX_CODE);
        end
        else if (g <= `AMP_GAIN_MAX_CODE)
        begin : g_step
            assign gain_dec[g] = (gain_code == 3'(g));
        end
        else
        begin : g_none
            assign gain_dec[g] = 1'b0;
        end
    end

    // ----------------------------------------
    // Drive decode
    // ----------------------------------------
    always_comb
    begin
        drive_d.use_secondary = ctrl_q[`AMP_SWEN_BIT] && timer_compare_switch_signal;
        if (drive_d.use_secondary)
        begin
            drive_d.noninv_sel = ctrl_q[`AMP_SNON_LSB +: 3];
            drive_d.inv_sel    = ctrl_q[`AMP_SINV_LSB +: 2];
        end
        else
        begin
            drive_d.noninv_sel = ctrl_q[`AMP_PNON_LSB +: 3];
            drive_d.inv_sel    = ctrl_q[`AMP_PINV_LSB +: 2];
        end
        // Code 111 routes no pin
        drive_d.noninv_valid = drive_d.noninv_sel <= `AMP_NON_MAX_CODE;
        // One-hot gain: bit 0 = x2 ... bit 4 = x32, bit 5 unused
        drive_d.gain = gain_dec;
        drive_d.mode   = amp_mode_type'(ctrl_q[`AMP_MODE_LSB +: 2]);
        drive_d.enable = ctrl_q[`AMP_EN_BIT];
    end

    // Lock clears only on reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q      <= `AMP_CTRL_RESET;
            lock_bit_q  <= 1'b0;
            lock_used_q <= 1'b0;
            rdata       <= 32'h0000_0000;
            drive       <= '0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            lock_bit_q  <= lock_bit_d;
            lock_used_q <= lock_used_d;
            rdata       <= rdata_d;
            drive       <= drive_d;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_locked_ctrl_hold: assert property (@(posedge clk) disable iff (rst)
        lock_bit_q |=> $stable(ctrl_q))
        else $error("control changed while locked");
    a_locked_no_err: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == `AMP_CTRL_OFFSET && lock_bit_q) |=> ctrl_q == $past(ctrl_q))
        else $error("locked write altered control");
    a_unlock_write: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == `AMP_CTRL_OFFSET && !lock_bit_q)
        |=> ctrl_q == ($past(wdata) & 32'h000e_eeff))
        else $error("unlocked write not stored");
    a_lock_once: assert property (@(posedge clk) disable iff (rst)
        lock_used_q |=> $stable(lock_bit_q))
        else $error("lock changed after first write");
    a_lock_first: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == `AMP_LOCK_OFFSET && !lock_used_q) |=> lock_bit_q == $past(wdata[0]))
        else $error("first lock write lost");
    a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
        lock_bit_q |=> lock_bit_q)
        else $error("lock cleared without reset");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q & 32'hfff1_1100) == 32'h0000_0000)
        else $error("reserved bits set");
    a_switch_sel: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[13] && timer_compare_switch_signal)
        |=> drive.noninv_sel == $past(ctrl_q[19:17]) && drive.inv_sel == $past(ctrl_q[15:14]))
        else $error("secondary select not applied");
    a_primary_sel: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[13] |=> drive.noninv_sel == $past(ctrl_q[11:9]) && !drive.use_secondary)
        else $error("primary select not applied");
    a_gain_map: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[5:3] == 3'h4) |=> drive.gain == 6'h10)
        else $error("gain code 4 not x32");
    a_read_data: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == `AMP_LOCK_OFFSET) |=> rdata == {31'h0, $past(lock_bit_q)})
        else $error("lock readback wrong");

    // ----------------------------------------
    // Register port assertions
    // ----------------------------------------
    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !rd
        |=> rdata == 32'h0000_0000)
        else $error("read data not cleared");
    a_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == `AMP_CTRL_OFFSET)
        |=> rdata == $past(ctrl_q))
        else $error("control readback wrong");
    a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
        (rd && addr != `AMP_CTRL_OFFSET && addr != `AMP_LOCK_OFFSET)
        |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
        !(wr && addr == `AMP_CTRL_OFFSET)
        |=> $stable(ctrl_q))
        else $error("control changed without write");
    a_lock_ignored: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == `AMP_LOCK_OFFSET && lock_used_q)
        |=> lock_bit_q == $past(lock_bit_q))
        else $error("second lock write took effect");
    a_lock_used_set: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == `AMP_LOCK_OFFSET)
        |=> lock_used_q)
        else $error("lock write not consumed");
    a_lock_used_hold: assert property (@(posedge clk) disable iff (rst)
        lock_used_q
        |=> lock_used_q)
        else $error("lock write token returned");
    a_lock_has_write: assert property (@(posedge clk) disable iff (rst)
        lock_bit_q |-> lock_used_q)
        else $error("lock set without a write");
    a_lock_idle_hold: assert property (@(posedge clk) disable iff (rst)
        !(wr && addr == `AMP_LOCK_OFFSET)
        |=> $stable(lock_bit_q))
        else $error("lock changed without write");

    // ----------------------------------------
    // Drive assertions
    // ----------------------------------------
    a_switch_flag: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[13] && timer_compare_switch_signal)
        |=> drive.use_secondary)
        else $error("switch flag not raised");
    a_timer_gated: assert property (@(posedge clk) disable iff (rst)
        !timer_compare_switch_signal
        |=> !drive.use_secondary)
        else $error("secondary used with timer low");
    a_timer_low_sel: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[13] && !timer_compare_switch_signal)
        |=> drive.noninv_sel == $past(ctrl_q[11:9]) && drive.inv_sel == $past(ctrl_q[7:6]))
        else $error("primary select not applied with timer low");
    a_primary_inv: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[13]
        |=> drive.inv_sel == $past(ctrl_q[7:6]))
        else $error("primary inverting select not applied");
    a_switch_off: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[13]
        |=> !drive.use_secondary)
        else $error("switching active while disabled");
    a_noninv_none: assert property (@(posedge clk) disable iff (rst)
        (!ctrl_q[13] && ctrl_q[11:9] == 3'h7)
        |=> !drive.noninv_valid)
        else $error("code 7 marked as a pin");
    a_noninv_pin: assert property (@(posedge clk) disable iff (rst)
        (!ctrl_q[13] && ctrl_q[11:9] != 3'h7)
        |=> drive.noninv_valid)
        else $error("pin code not marked valid");
    a_gain_x2: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[5:3] == 3'h0)
        |=> drive.gain == 6'h01)
        else $error("gain code 0 not x2");
    a_gain_x4: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[5:3] == 3'h1)
        |=> drive.gain == 6'h02)
        else $error("gain code 1 not x4");
    a_gain_x8: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[5:3] == 3'h2)
        |=> drive.gain == 6'h04)
        else $error("gain code 2 not x8");
    a_gain_x16: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[5:3] == 3'h3)
        |=> drive.gain == 6'h08)
        else $error("gain code 3 not x16");
    a_gain_other: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[5:3] > 3'h4)
        |=> drive.gain == 6'h01)
        else $error("undefined gain code not x2");
    a_gain_top_unused: assert property (@(posedge clk) disable iff (rst)
        !drive.gain[5])
        else $error("unused gain step driven");
    a_mode_follow: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[2:1] == 2'h3)
        |=> drive.mode == mode_follow_type_e)
        else $error("follower mode not applied");
    a_mode_pga: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[2:1] == 2'h2)
        |=> drive.mode == mode_pga_type_e)
        else $error("internal gain mode not applied");
    a_mode_ext: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[2]
        |=> !drive.mode[1])
        else $error("external mode not applied");
    a_enable_on: assert property (@(posedge clk) disable iff (rst)
        ctrl_q[0]
        |=> drive.enable)
        else $error("enable not applied");
    a_enable_off: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q[0]
        |=> !drive.enable)
        else $error("disable not applied");

    c_lock_set:   cover property (@(posedge clk) disable iff (rst)
        wr && addr == `AMP_LOCK_OFFSET && wdata[0] && !lock_used_q);
    c_locked_wr:  cover property (@(posedge clk) disable iff (rst)
        wr && addr == `AMP_CTRL_OFFSET && lock_bit_q);
    c_secondary:  cover property (@(posedge clk) disable iff (rst) drive.use_secondary);
    c_follow:     cover property (@(posedge clk) disable iff (rst)
        drive.mode == mode_follow_type_e && drive.enable);
    // A first lock write of 0 leaves the bank open until reset
    c_lock_zero:  cover property (@(posedge clk) disable iff (rst)
        wr && addr == `AMP_LOCK_OFFSET && !wdata[0] && !lock_used_q);

endmodule

// File: shared/amp_cfg.svh
// Register offsets, field positions, reset values of the amplifier register bank
//
// Contract
// - Primary non-inverting select, bits 11:9, codes 000..110 pick seven pins.
// - Secondary non-inverting select, bits 19:17, same encoding as primary.
// - Inverting selects at 7:6 and 15:14, four codes pick four pins.
// - Bit 13 enables timer-driven switching between primary and secondary selects.
// - Switching enabled and timer signal high selects secondary, else primary.
// - Gain code 5:3 gives 2,4,8,16,32 for 000..100, others give 2.
// - Mode 2:1: 0x external, 10 internal gain, 11 follower; bit 0 enables.
// - Lock bit 0 of lock register takes only the first write after reset.
// - Control register is read-only while locked, read-write while unlocked.
// - Only chip reset clears the lock; software cannot.
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define AMP_CTRL_OFFSET   8'h00
`define AMP_LOCK_OFFSET   8'h04

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define AMP_EN_BIT        0
`define AMP_MODE_LSB      1
`define AMP_GAIN_LSB      3
`define AMP_PINV_LSB      6
`define AMP_PNON_LSB      9
`define AMP_SWEN_BIT      13
`define AMP_SINV_LSB      14
`define AMP_SNON_LSB      17
`define AMP_LOCK_BIT      0
`define AMP_CTRL_WMASK    32'h000e_eefe
`define AMP_CTRL_WMASK_EN 32'h0000_0001
`define AMP_CTRL_RESET    32'h0000_0000
`define AMP_NON_MAX_CODE  3'h6
`define AMP_GAIN_MAX_CODE 3'h4

`endif

// File: shared/amp_pkg.sv
// Types of the amplifier register bank
package amp_pkg;

    typedef enum logic [1:0]
    {
        mode_ext_lo_type_e = 2'h0,
        mode_ext_hi_type_e = 2'h1,
        mode_pga_type_e    = 2'h2,
        mode_follow_type_e = 2'h3
    } amp_mode_type;

    typedef struct packed
    {
        logic         enable;
        amp_mode_type mode;
        logic [5:0]   gain;
        logic [2:0]   noninv_sel;
        logic [1:0]   inv_sel;
        logic         noninv_valid;
        logic         use_secondary;
    } amp_drive_type;

endpackage

// File: testbench/test_amp_regs.sv
// Self-checking bench for the amplifier register bank
`timescale 1ns/1ps
module test_amp_regs;
    logic                   clk;
    logic                   rst;
    logic                   wr;
    logic                   rd;
    logic                   timer_sig;
    logic [7:0]             addr;
    logic [31:0]            wdata;
    logic [31:0]            rdata;
    logic [31:0]            r;
    amp_pkg::amp_drive_type drive;
    int                     n_errors;
    int                     checked;
    amp_regs amp_regs_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer_compare_switch_signal(timer_sig), .drive(drive));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Reference drive worked out from the field layout
    function automatic logic [15:0] exp_drive(input logic [31:0] c, input logic t);
        amp_pkg::amp_drive_type e;
        e.use_secondary = c[13] & t;
        e.enable = c[0];
        e.mode = amp_pkg::amp_mode_type'(c[2:1]);
        e.gain = (c[5:3] <= 3'h4) ? (6'h01 << c[5:3]) : 6'h01;
        e.noninv_sel = e.use_secondary ? c[19:17] : c[11:9];
        e.inv_sel = e.use_secondary ? c[15:14] : c[7:6];
        e.noninv_valid = (e.noninv_sel <= 3'h6);
        return e;
    endfunction
    // Write control, then judge drive and readback
    task put(input logic [31:0] c);
        bus_wr(8'h00, c & 32'h000e_eeff);
        @(posedge clk);
        #1 chk(16'(drive), exp_drive(c, timer_sig));
        bus_rd(8'h00, r);
        chk(r, c & 32'h000e_eeff);
    endtask
    task close_out;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_fields;
        for (int i = 0; i < 8; i++)
            put((i << 9) | (i << 3) | ((i & 3) << 6) | ((i & 3) << 1) | (i & 1));
        put(32'hffff_ffff);
        $display("fields done");
    endtask
    task t_switch;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            timer_sig <= i[1];
            put(32'h000a_8000 | (i[0] << 13) | 32'h0000_0440);
        end
        @(posedge clk);
        timer_sig <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(16'(drive), exp_drive(32'h000a_a440, 1'b0));
        $display("switch done");
    endtask
    task t_lock;
        put(32'h0000_0a55);
        bus_wr(8'h04, 32'h1);
        bus_wr(8'h00, 32'h000e_eeff);
        put_check_locked();
        bus_wr(8'h04, 32'h0);
        bus_rd(8'h04, r);
        chk(r, 32'h1);
        bus_rd(8'h08, r);
        chk(r, 32'h0);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        bus_rd(8'h00, r);
        chk(r, 32'h0);
        bus_wr(8'h04, 32'h0);
        bus_wr(8'h04, 32'h1);
        bus_rd(8'h04, r);
        chk(r, 32'h0);
        put(32'h0000_1234);
        $display("lock done");
    endtask
    task put_check_locked;
        bus_rd(8'h00, r);
        chk(r, 32'h0000_0a55);
        chk(16'(drive), exp_drive(32'h0000_0a55, timer_sig));
    endtask
    initial
    begin
        #1_000_000;
        n_errors++;
        close_out;
    end
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        timer_sig = 1'b0;
        n_errors = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus_rd(8'h04, r);
        chk(r, 32'h0);
        t_fields;
        t_switch;
        t_lock;
        close_out;
    end
endmodule
